// ==== wdt_pkg.sv ====
/*
  Shared constants for the start-up watchdog: register map, field layout,
  reset values and prescaler figures.
  Assumes a single 250 MHz clock domain and an AXI4-Lite register bus.
*/
package wdt_pkg;

  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] cmd_addr = 8'h04;
  localparam logic [7:0] count_addr = 8'h08;
  localparam logic [7:0] status_addr = 8'h0c;
  localparam logic [7:0] mask_addr = 8'h10;

  localparam int reload_lsb = 8;
  localparam int prescale_bit = 0;

  localparam int cmd_service_bit = 0;
  localparam int cmd_disable_bit = 1;
  localparam int cmd_end_init_bit = 2;

  localparam int st_overflow_bit = 0;
  localparam int st_end_init_bit = 1;
  localparam int st_service_bit = 2;

  localparam logic [7:0] reload_reset = 8'h00;
  localparam logic prescale_reset = 1'b0;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [2:0] mask_reset = 3'h0;

  localparam int div_slow = 128;
  localparam int div_fast = 2;
  localparam logic [6:0] div_fast_last = 7'(div_fast - 1);
  localparam logic [6:0] div_slow_last = 7'(div_slow - 1);

  // Cycles the internal reset is held after an overflow.
  localparam int hold_ns = 100;
  localparam int clk_ns = 4;
  localparam logic [7:0] hold_cycles = 8'((hold_ns + clk_ns - 1) / clk_ns);

  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

endpackage

// ==== wdt_prescaler.sv ====
/*
  Prescaler for the watchdog counter: emits a one-cycle tick every 2 or
  every 128 clocks depending on the select input.
  Assumes the restart input is pulsed whenever the counter is serviced.
*/
`timescale 1ns/1ps
module wdt_prescaler (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic slow,
  // Result
  output logic tick
);

  typedef struct packed {
    logic [6:0] cnt;
  } pre_s;

  pre_s state_reg;
  pre_s state_next;
  logic [6:0] last;

  always_comb begin
    state_next = state_reg;
    last = slow ? wdt_pkg::div_slow_last : wdt_pkg::div_fast_last; // [RULE6]
    tick = 1'b0;
    if (restart || !run) begin
      state_next.cnt = 7'h00;
    end else if (state_reg.cnt >= last) begin
      // The >= keeps a switch from 128 to 2 from stranding a high count.
      state_next.cnt = 7'h00;
      tick = 1'b1;
    end else begin
      state_next.cnt = state_reg.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

// ==== wdt_top.sv ====
/*
  Start-up watchdog timer with an AXI4-Lite register slave.
  Assumes one clock, an asynchronous active-low chip reset, and that the
  chip reset controller feeds the internal reset request back to nrst.
*/
`timescale 1ns/1ps
// How it works
// [RULE1] The counter is enabled and running after every chip reset.
// [RULE2] Disable works only before end of initialization, then is ignored.
// [RULE3] Software must service before overflow in normal operation.
// [RULE4] Counter overflow raises an internal hardware reset request.
// [RULE5] A watchdog reset drives the reset output pin low.
// [RULE6] 16-bit counter advances at clock divided by 2 or by 128.
// [RULE7] Each service loads the counter high byte with the reload value.
// [RULE8] Timeout is (256 minus reload) times 256 prescaled clocks.
// [RULE9] End of initialization releases the reset output, closes disabling.
// [RULE10] Software rewrites the control register before each service.
// [RULE11] Service clears the low byte; overflow is the wrap past all ones.
// [RULE12] Reset clears counter and reload and selects divide by 2.
module wdt_top (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reset outputs and interrupt
  output logic reset_out_pin_n,
  output logic wdt_reset_req,
  output logic irq
);

  typedef struct packed {
    logic [7:0] reload;
    logic prescale;
    logic [15:0] count;
    logic enabled;
    logic end_init;
    logic [7:0] hold;
    logic rst_out_n;
    logic [2:0] status;
    logic [2:0] mask;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
  } wdt_s;

  wdt_s state_reg;
  wdt_s state_next;
  logic tick;
  logic do_write;
  logic do_read;
  logic service;
  logic pre_restart;
  logic [2:0] events;

  // Write decode.
  logic aw_take;
  logic w_take;
  logic b_done;
  logic r_done;
  logic lane0;
  logic lane1;
  logic wr_known;
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_mask;
  logic cmd_disable;
  logic cmd_end_init;
  logic disable_ok;
  logic end_init_ok;

  // Counter decode.
  logic count_tick;
  logic overflow;
  logic hold_busy;

  // Read decode.
  logic rd_clear;
  logic [31:0] ctrl_word;
  logic [31:0] cmd_word;
  logic [31:0] count_word;
  logic [31:0] status_word;
  logic [31:0] mask_word;

  wdt_prescaler prescaler (
    .clk(clk),
    .nrst(nrst),
    .run(state_reg.enabled),
    .restart(pre_restart),
    .slow(state_reg.prescale),
    .tick(tick)
  );

  assign s_axi_awready = !state_reg.aw_full;
  assign s_axi_wready = !state_reg.w_full;
  assign s_axi_arready = !state_reg.r_valid;
  assign s_axi_bvalid = state_reg.b_valid;
  assign s_axi_bresp = state_reg.b_resp;
  assign s_axi_rvalid = state_reg.r_valid;
  assign s_axi_rdata = state_reg.r_data;
  assign s_axi_rresp = state_reg.r_resp;
  assign reset_out_pin_n = state_reg.rst_out_n;
  assign wdt_reset_req = (state_reg.hold != 8'h00);
  assign irq = |(state_reg.status & state_reg.mask);

  // A write executes once both halves are latched and no answer is pending.
  assign aw_take = s_axi_awvalid && !state_reg.aw_full;
  assign w_take = s_axi_wvalid && !state_reg.w_full;
  assign b_done = state_reg.b_valid && s_axi_bready;
  assign r_done = state_reg.r_valid && s_axi_rready;
  assign do_write = state_reg.aw_full && state_reg.w_full &&
    !state_reg.b_valid;
  assign do_read = s_axi_arvalid && !state_reg.r_valid;

  assign lane0 = state_reg.w_strb[0];
  assign lane1 = state_reg.w_strb[1];
  assign wr_known = state_reg.aw_addr == wdt_pkg::ctrl_addr ||
    state_reg.aw_addr == wdt_pkg::cmd_addr ||
    state_reg.aw_addr == wdt_pkg::count_addr ||
    state_reg.aw_addr == wdt_pkg::status_addr ||
    state_reg.aw_addr == wdt_pkg::mask_addr;
  assign wr_ctrl = do_write && state_reg.aw_addr == wdt_pkg::ctrl_addr;
  assign wr_cmd = do_write && state_reg.aw_addr == wdt_pkg::cmd_addr;
  assign wr_mask = do_write && state_reg.aw_addr == wdt_pkg::mask_addr;

  // Command bits are pulses; each acts only in the cycle the write executes.
  assign service = wr_cmd && lane0 &&
    state_reg.w_data[wdt_pkg::cmd_service_bit];
  assign cmd_disable = wr_cmd && lane0 &&
    state_reg.w_data[wdt_pkg::cmd_disable_bit];
  assign cmd_end_init = wr_cmd && lane0 &&
    state_reg.w_data[wdt_pkg::cmd_end_init_bit];
  assign disable_ok = cmd_disable && !state_reg.end_init; // [RULE2]
  assign end_init_ok = cmd_end_init && !state_reg.end_init; // [RULE9]
  assign pre_restart = service;

  // A service in the same cycle as a tick wins, so no count is lost twice.
  assign count_tick = state_reg.enabled && tick && !service; // [RULE6] [RULE8]
  assign overflow = count_tick && state_reg.count == 16'hffff; // [RULE11]
  assign hold_busy = state_reg.hold != 8'h00;

  assign rd_clear = do_read && s_axi_araddr == wdt_pkg::status_addr;
  assign ctrl_word = (32'(state_reg.reload) << wdt_pkg::reload_lsb) |
    (32'(state_reg.prescale) << wdt_pkg::prescale_bit);
  assign cmd_word = (32'(!state_reg.enabled) << wdt_pkg::cmd_disable_bit) |
    (32'(state_reg.end_init) << wdt_pkg::cmd_end_init_bit);
  assign count_word = {16'h0000, state_reg.count};
  assign status_word = {29'h00000000, state_reg.status};
  assign mask_word = {29'h00000000, state_reg.mask};

  always_comb begin
    state_next = state_reg;
    events = 3'h0;

    // Address and data are latched independently, in either order.
    if (aw_take) begin
      state_next.aw_full = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      state_next.w_full = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (b_done) begin
      state_next.b_valid = 1'b0;
    end

    if (do_write) begin
      state_next.aw_full = 1'b0;
      state_next.w_full = 1'b0;
      state_next.b_valid = 1'b1;
      if (wr_known) begin
        state_next.b_resp = wdt_pkg::resp_okay;
      end else begin
        state_next.b_resp = wdt_pkg::resp_slverr;
      end
    end

    if (wr_ctrl && lane0) begin
      state_next.prescale = state_reg.w_data[wdt_pkg::prescale_bit]; // [RULE6]
    end
    if (wr_ctrl && lane1) begin
      state_next.reload =
        state_reg.w_data[wdt_pkg::reload_lsb +: 8]; // [RULE7]
    end
    if (wr_mask && lane0) begin
      state_next.mask = state_reg.w_data[2:0];
    end

    if (disable_ok) begin
      state_next.enabled = 1'b0; // [RULE2]
    end
    if (end_init_ok) begin
      state_next.end_init = 1'b1; // [RULE9]
      state_next.rst_out_n = 1'b1; // [RULE9]
      events[wdt_pkg::st_end_init_bit] = 1'b1;
    end

    // Counter: service reloads, otherwise counts up on prescaler ticks.
    if (service) begin
      state_next.count = {state_reg.reload, 8'h00}; // [RULE7] [RULE11]
      events[wdt_pkg::st_service_bit] = 1'b1;
    end else if (count_tick) begin
      state_next.count = state_reg.count + 16'h0001; // [RULE6]
    end
    if (hold_busy) begin
      state_next.hold = state_reg.hold - 8'h01;
    end
    // Overflow comes last so it wins over a release in the same cycle.
    if (overflow) begin
      state_next.hold = wdt_pkg::hold_cycles; // [RULE4] [RULE11]
      state_next.rst_out_n = 1'b0; // [RULE5]
      events[wdt_pkg::st_overflow_bit] = 1'b1;
    end

    // Read, with read-to-clear status; new events win over the clear.
    if (r_done) begin
      state_next.r_valid = 1'b0;
    end
    if (do_read) begin
      state_next.r_valid = 1'b1;
      state_next.r_resp = wdt_pkg::resp_okay;
      unique case (s_axi_araddr)
        wdt_pkg::ctrl_addr: begin
          state_next.r_data = ctrl_word;
        end
        wdt_pkg::cmd_addr: begin
          state_next.r_data = cmd_word;
        end
        wdt_pkg::count_addr: begin
          state_next.r_data = count_word;
        end
        wdt_pkg::status_addr: begin
          state_next.r_data = status_word;
        end
        wdt_pkg::mask_addr: begin
          state_next.r_data = mask_word;
        end
        default: begin
          state_next.r_data = 32'h00000000;
          state_next.r_resp = wdt_pkg::resp_slverr;
        end
      endcase
    end
    if (rd_clear) begin
      state_next.status = 3'h0;
    end
    state_next.status = state_next.status | events;
  end

  // Reset leaves the watchdog running with the longest count at divide by 2.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
      state_reg.enabled <= 1'b1; // [RULE1]
      state_reg.reload <= wdt_pkg::reload_reset; // [RULE12]
      state_reg.prescale <= wdt_pkg::prescale_reset; // [RULE12]
      state_reg.count <= wdt_pkg::count_reset; // [RULE12]
      state_reg.mask <= wdt_pkg::mask_reset;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

// ==== wdt_monitor.sv ====
/*
  Port checker for the start-up watchdog top module.
  Assumes it is bound to wdt_top and sees one clock domain.
*/
`timescale 1ns/1ps
module wdt_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus responses
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Reset outputs
  input wire logic reset_out_pin_n,
  input wire logic wdt_reset_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Saturating age since reset; no timeout can be shorter than 512 clocks.
  logic [9:0] age;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) age <= 10'h000;
    else if (age != 10'h3ff) age <= age + 10'h001;
  end
  property p_pin_low; wdt_reset_req |-> !reset_out_pin_n; endproperty
  property p_req_late; wdt_reset_req |-> age >= 10'h1f4; endproperty
  property p_req_hold; $rose(wdt_reset_req) |-> wdt_reset_req[*8]; endproperty
  property p_req_end; $rose(wdt_reset_req) |-> ##25 !wdt_reset_req; endproperty
  property p_pin_rise; $rose(reset_out_pin_n) |-> ##[0:1] s_axi_bvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_ar_r; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin high in req");
  a_req_late: assert property (p_req_late) else $error("req too soon");
  a_req_hold: assert property (p_req_hold) else $error("req short");
  a_req_end: assert property (p_req_end) else $error("req length");
  a_pin_rise: assert property (p_pin_rise) else $error("pin rise");
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  a_ar_r: assert property (p_ar_r) else $error("read answer late");
  c_req: cover property ($rose(wdt_reset_req));
  c_pin: cover property ($rose(reset_out_pin_n));
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind wdt_top wdt_monitor u_mon (.clk(clk), .nrst(nrst),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .reset_out_pin_n(reset_out_pin_n), .wdt_reset_req(wdt_reset_req));

// ==== tb_top.sv ====
/*
  Self-checking bench for the start-up watchdog over its register bus.
  Assumes the 250 MHz clock and the register map of wdt_pkg.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rd, rd2;
  logic [1:0] resp;
  logic aok, wok, done;
  logic awready, wready, bvalid, arready, rvalid, pin_n, req, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int mismatches, compares, n;

  wdt_top u_dut (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .reset_out_pin_n(pin_n), .wdt_reset_req(req), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    // Handshakes are sampled mid-cycle, where they stand for the next edge.
    while (!done) begin
      @(negedge clk);
      aok = awvalid && awready;
      wok = wvalid && wready;
      done = bvalid;
      resp = bresp;
      @(posedge clk);
      if (aok) awvalid <= 1'b0;
      if (wok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task rdr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge clk);
      aok = arvalid && arready;
      done = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge clk);
      if (aok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task do_reset;
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
  endtask

  task stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    stop_test;
  end

  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    mismatches = 0;
    compares = 0;
    do_reset;
    chk(pin_n, 1'b0);
    rdr(wdt_pkg::ctrl_addr);
    chk(rd, 32'h0);
    rdr(wdt_pkg::cmd_addr);
    chk(rd[1], 1'b0);
    rdr(wdt_pkg::count_addr);
    rd2 = rd;
    rdr(wdt_pkg::count_addr);
    chk(rd != rd2, 1'b1);
    // Shortest timeout: all-ones reload at divide by 2 is 512 clocks.
    wr(wdt_pkg::mask_addr, 32'h1);
    wr(wdt_pkg::ctrl_addr, 32'h0000ff00);
    wr(wdt_pkg::cmd_addr, 32'h1);
    n = 0;
    while (req !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk(n >= 505 && n <= 520, 1'b1);
    repeat (2) @(posedge clk);
    chk(pin_n, 1'b0);
    chk(irq, 1'b1);
    rdr(wdt_pkg::status_addr);
    chk(rd[0], 1'b1);
    chk(irq, 1'b0);
    do_reset;
    wr(wdt_pkg::cmd_addr, 32'h2);
    rdr(wdt_pkg::cmd_addr);
    chk(rd[1], 1'b1);
    rdr(wdt_pkg::count_addr);
    rd2 = rd;
    rdr(wdt_pkg::count_addr);
    chk(rd, rd2);
    do_reset;
    wr(wdt_pkg::cmd_addr, 32'h4);
    chk(pin_n, 1'b1);
    wr(wdt_pkg::cmd_addr, 32'h2);
    rdr(wdt_pkg::cmd_addr);
    chk(rd[2:1], 2'b10);
    // Regular service inside the 512-clock period never lets it overflow.
    repeat (4) begin
      wr(wdt_pkg::ctrl_addr, 32'h0000ff00);
      wr(wdt_pkg::cmd_addr, 32'h1);
      repeat (300) @(posedge clk);
      chk(req, 1'b0);
      chk(pin_n, 1'b1);
    end
    wr(wdt_pkg::ctrl_addr, 32'h0000ff01);
    wr(wdt_pkg::cmd_addr, 32'h1);
    repeat (300) @(posedge clk);
    rdr(wdt_pkg::count_addr);
    chk(rd[15:8], 8'hff);
    chk(rd[7:0] >= 8'h01 && rd[7:0] <= 8'h03, 1'b1);
    wr(8'h20, 32'h0);
    chk(resp, wdt_pkg::resp_slverr);
    rdr(8'h20);
    chk(resp, wdt_pkg::resp_slverr);
    stop_test;
  end
endmodule
